// ### include/nmi_guard_pkg.sv
// constants for the nmi arbitration and boot-loader guard block
// assumes a 20-bit byte address bus and 16-bit vector words
package nmi_guard_pkg;
    localparam int          ADDR_W        = 20;
    localparam int          VEC_W         = 16;
    localparam int          USR_SRC_DEF   = 4;
    localparam int          SYS_SRC_DEF   = 4;
    // protected entry window: 0x01C00..0x01C0F, sixteen bytes
    localparam logic [19:0] SECURE_BASE   = 20'h01C00;
    localparam int          SECURE_LSB    = 4;
    // vector code of source i is (i+1)*VEC_STEP; zero means none pending
    localparam logic [15:0] VEC_STEP      = 16'h0002;
    localparam logic [15:0] VEC_NONE      = 16'h0000;
endpackage

// ### verilog/nmi_guard.sv
// system nmi arbitration, vector read/clear, return ordering and boot-loader ram guard
// assumes a cpu that reports vector reads, handler entry/return and instruction retire
// as one-cycle pulses synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none

// Function
// - with ram as secured boot area, protect only 0x01C00 through 0x01C0F
// - ram windows at 0x01D00, 0x01E00, 0x01F00, 0x02000, 0x02B00 stay open
// - any access to a secured location raises a security reset
// - user vector read clears only the serviced flag, lower flags stay set
// - higher nmi arriving during vector fetch stays pending, no double lower run
// - user and system nmis have separate flags, vectors and arbitration
// - after system handler return, run one instruction before a pending irq
// - system nmis outrank user nmis; user nmi never preempts system handler
module nmi_guard
    import nmi_guard_pkg::*;
#(
    parameter int USR_SRC = nmi_guard_pkg::USR_SRC_DEF,
    parameter int SYS_SRC = nmi_guard_pkg::SYS_SRC_DEF
) (
    input  wire logic                              core_clk,
    input  wire logic                              srst,
    input  wire logic [USR_SRC-1:0]                usr_nmi_set,
    input  wire logic [SYS_SRC-1:0]                sys_nmi_set,
    input  wire logic                              usr_vec_rd,
    input  wire logic                              sys_vec_rd,
    output logic      [nmi_guard_pkg::VEC_W-1:0]   user_nmi_vector_register,
    output logic      [nmi_guard_pkg::VEC_W-1:0]   sys_nmi_vector,
    output logic                                   user_nonmaskable_irq,
    output logic                                   system_nonmaskable_irq,
    input  wire logic                              sys_handler_enter,
    input  wire logic                              sys_handler_return,
    input  wire logic                              instr_retire,
    input  wire logic                              irq_pending,
    output logic                                   irq_grant,
    input  wire logic                              acc_valid,
    input  wire logic [nmi_guard_pkg::ADDR_W-1:0]  acc_addr,
    input  wire logic                              boot_protect_en,
    input  wire logic                              boot_loader_region_in_ram,
    output logic                                   security_reset
);
    import nmi_guard_pkg::*;

    initial begin
        if (USR_SRC < 1 || USR_SRC > 16 || SYS_SRC < 1 || SYS_SRC > 16) begin
            $error("nmi_guard: source counts must be 1..16");
        end
    end

    typedef struct packed {
        logic [USR_SRC-1:0] usr_flags;
        logic [SYS_SRC-1:0] sys_flags;
        logic [VEC_W-1:0]   usr_vec;
        logic [VEC_W-1:0]   sys_vec;
        logic               sys_active;
        logic               irq_hold;
        logic               sec_rst;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [USR_SRC-1:0] usr_clr;
    logic [SYS_SRC-1:0] sys_clr;
    logic               secured_hit;

    always_comb begin
        st_nxt  = st_r;
        usr_clr = '0;
        sys_clr = '0;
        // clear index taken from the vector the cpu actually read, so a flag
        // that lands in the same cycle is never the one removed
        for (int i = 0; i < USR_SRC; i++) begin
            if (usr_vec_rd && st_r.usr_vec == VEC_W'((i + 1) * VEC_STEP)) begin
                usr_clr[i] = 1'b1;
            end
        end
        for (int i = 0; i < SYS_SRC; i++) begin
            if (sys_vec_rd && st_r.sys_vec == VEC_W'((i + 1) * VEC_STEP)) begin
                sys_clr[i] = 1'b1;
            end
        end
        // set wins over clear
        st_nxt.usr_flags = (st_r.usr_flags & ~usr_clr) | usr_nmi_set;
        st_nxt.sys_flags = (st_r.sys_flags & ~sys_clr) | sys_nmi_set;
        // lowest index is highest priority; scan from the top index down, the last hit wins
        st_nxt.usr_vec = VEC_NONE;
        for (int i = USR_SRC - 1; i >= 0; i--) begin
            if (st_nxt.usr_flags[i]) begin
                st_nxt.usr_vec = VEC_W'((i + 1) * VEC_STEP);
            end
        end
        st_nxt.sys_vec = VEC_NONE;
        for (int i = SYS_SRC - 1; i >= 0; i--) begin
            if (st_nxt.sys_flags[i]) begin
                st_nxt.sys_vec = VEC_W'((i + 1) * VEC_STEP);
            end
        end
        if (sys_handler_enter) begin
            st_nxt.sys_active = 1'b1;
        end else if (sys_handler_return) begin
            st_nxt.sys_active = 1'b0;
        end
        // one instruction of the interrupted program must retire first
        if (sys_handler_return) begin
            st_nxt.irq_hold = 1'b1;
        end else if (instr_retire) begin
            st_nxt.irq_hold = 1'b0;
        end
        st_nxt.sec_rst = secured_hit;
        if (srst) begin
            st_nxt = '0;
        end
    end

    // exact sixteen-byte match; the mirrored windows are not decoded at all
    assign secured_hit = acc_valid && boot_protect_en && boot_loader_region_in_ram
                         && (acc_addr[ADDR_W-1:SECURE_LSB] == SECURE_BASE[ADDR_W-1:SECURE_LSB]);

    always_ff @(posedge core_clk) begin
        st_r <= st_nxt;
    end

    assign user_nmi_vector_register = st_r.usr_vec;
    assign sys_nmi_vector           = st_r.sys_vec;
    assign system_nonmaskable_irq   = (st_r.sys_vec != VEC_NONE);
    // user requests are held back entirely while a system handler runs
    assign user_nonmaskable_irq     = (st_r.usr_vec != VEC_NONE) && !st_r.sys_active
                                      && !system_nonmaskable_irq;
    assign irq_grant                = irq_pending && !st_r.sys_active && !st_r.irq_hold;
    assign security_reset           = st_r.sec_rst;

    // guard window checks
    window_exact_a: assert property (@(posedge core_clk) disable iff (srst)
        acc_valid && boot_protect_en && boot_loader_region_in_ram && acc_addr >= 20'h01C00 && acc_addr <= 20'h01C0F
        |=> security_reset) else $error("secured window access gave no reset");

    outside_open_a: assert property (@(posedge core_clk) disable iff (srst)
        acc_valid && acc_addr[ADDR_W-1:SECURE_LSB] != SECURE_BASE[ADDR_W-1:SECURE_LSB] |=> !security_reset)
        else $error("address outside window raised a reset");

    ram_only_a: assert property (@(posedge core_clk) disable iff (srst)
        !boot_loader_region_in_ram |=> !security_reset)
        else $error("reset raised with ram not selected");

    mirror_open_a: assert property (@(posedge core_clk) disable iff (srst)
        acc_valid && (acc_addr[19:4] == 16'h01D0 || acc_addr[19:4] == 16'h01E0 || acc_addr[19:4] == 16'h01F0
        || acc_addr[19:4] == 16'h0200 || acc_addr[19:4] == 16'h02B0) |=> !security_reset)
        else $error("mirror window raised a reset");

    reset_cause_a: assert property (@(posedge core_clk) disable iff (srst)
        security_reset |-> $past(acc_valid) && $past(boot_protect_en) && $past(boot_loader_region_in_ram))
        else $error("security reset without secured access");

    reset_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
        !acc_valid |=> !security_reset)
        else $error("security reset outlived its access");

    // user vector read and clear
    single_clear_a: assert property (@(posedge core_clk) disable iff (srst)
        usr_vec_rd |=> $countones($past(st_r.usr_flags) & ~st_r.usr_flags) <= 1)
        else $error("vector read cleared more than one flag");

    keep_lower_a: assert property (@(posedge core_clk) disable iff (srst)
        usr_vec_rd ##1 usr_vec_rd |=> $countones($past(st_r.usr_flags, 2) & ~st_r.usr_flags) <= 2)
        else $error("back-to-back reads lost a flag");

    arrive_kept_a: assert property (@(posedge core_clk) disable iff (srst)
        usr_vec_rd && usr_nmi_set[0] |=> st_r.usr_flags[0] ##0 user_nmi_vector_register == VEC_STEP)
        else $error("nmi arriving during fetch was lost");

    set_wins_a: assert property (@(posedge core_clk) disable iff (srst)
        (|usr_nmi_set) |=> (st_r.usr_flags & $past(usr_nmi_set)) == $past(usr_nmi_set))
        else $error("arriving user nmi was dropped");

    // system side keeps its own flags
    types_apart_a: assert property (@(posedge core_clk) disable iff (srst)
        usr_vec_rd && !sys_vec_rd && !(|sys_nmi_set) |=> st_r.sys_flags == $past(st_r.sys_flags))
        else $error("user read touched system flags");

    sys_clear_a: assert property (@(posedge core_clk) disable iff (srst)
        sys_vec_rd |=> $countones($past(st_r.sys_flags) & ~st_r.sys_flags) <= 1)
        else $error("system read cleared more than one flag");

    sys_set_kept_a: assert property (@(posedge core_clk) disable iff (srst)
        (|sys_nmi_set) |=> (st_r.sys_flags & $past(sys_nmi_set)) == $past(sys_nmi_set))
        else $error("arriving system nmi was dropped");

    // return ordering
    one_instr_a: assert property (@(posedge core_clk) disable iff (srst)
        sys_handler_return && !instr_retire ##1 !instr_retire |-> !irq_grant)
        else $error("irq granted before one instruction ran");

    no_grant_active_a: assert property (@(posedge core_clk) disable iff (srst)
        st_r.sys_active |-> !irq_grant)
        else $error("irq granted inside system handler");

    grant_free_a: assert property (@(posedge core_clk) disable iff (srst)
        irq_pending && !st_r.sys_active && !st_r.irq_hold |-> irq_grant)
        else $error("free irq was not granted");

    // priority between the two types
    sys_first_a: assert property (@(posedge core_clk) disable iff (srst)
        (system_nonmaskable_irq || st_r.sys_active) |-> !user_nonmaskable_irq)
        else $error("user nmi disturbed system nmi");

    usr_irq_up_a: assert property (@(posedge core_clk) disable iff (srst)
        st_r.usr_vec != VEC_NONE && !st_r.sys_active && !system_nonmaskable_irq |-> user_nonmaskable_irq)
        else $error("pending user nmi not requested");

    sys_irq_up_a: assert property (@(posedge core_clk) disable iff (srst)
        st_r.sys_flags != '0 |-> system_nonmaskable_irq)
        else $error("pending system nmi not requested");

    // vector codes
    empty_zero_a: assert property (@(posedge core_clk) disable iff (srst)
        st_r.usr_flags == '0 |-> user_nmi_vector_register == VEC_NONE)
        else $error("vector nonzero with no flag");

    usr_nonzero_a: assert property (@(posedge core_clk) disable iff (srst)
        st_r.usr_flags != '0 |-> user_nmi_vector_register != VEC_NONE)
        else $error("user vector zero with flag pending");

    top_code_a: assert property (@(posedge core_clk) disable iff (srst)
        st_r.usr_flags[0] |-> user_nmi_vector_register == VEC_STEP)
        else $error("user vector missed top flag");

    sys_zero_a: assert property (@(posedge core_clk) disable iff (srst)
        st_r.sys_flags == '0 |-> sys_nmi_vector == VEC_NONE)
        else $error("system vector nonzero with no flag");

    sys_top_a: assert property (@(posedge core_clk) disable iff (srst)
        st_r.sys_flags[0] |-> sys_nmi_vector == VEC_STEP)
        else $error("system vector missed top flag");
endmodule

`default_nettype wire

// ### tb/cpu_model.sv
// cpu stand-in: runs one system nmi handler each time go pulses
// assumes go is driven at the falling edge of core_clk
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    input  wire logic core_clk,
    input  wire logic go,
    output logic      sys_handler_enter,
    output logic      sys_handler_return,
    output logic      instr_retire
);
    logic [2:0] ph_r = 3'h0;
    // fixed schedule: enter, gap, return, gap, then one resumed instruction
    always @(negedge core_clk) begin
        ph_r <= go ? 3'h1 : ((ph_r != 3'h0 && ph_r < 3'h6) ? ph_r + 3'h1 : 3'h0);
    end
    assign sys_handler_enter  = ph_r == 3'h1;
    assign sys_handler_return = ph_r == 3'h3;
    assign instr_retire       = ph_r == 3'h5;
endmodule
`default_nettype wire

// ### tb/testbench.sv
// directed bench for nmi_guard with a cpu stand-in
// assumes outputs settle before the falling edge, where inputs change
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import nmi_guard_pkg::*;
    logic        core_clk = 1'b0, srst = 1'b1, go = 1'b0, urd = 1'b0, srd = 1'b0, irq = 1'b0, accv = 1'b0;
    logic        pen = 1'b1, pram = 1'b1;
    logic [3:0]  uset = 4'h0, sset = 4'h0;
    logic [19:0] addr = 20'h00000;
    logic [15:0] uvec, svec;
    logic        uirq, sirq, grant, sec, enter, ret, retire;
    int          mismatches = 0, check_count = 0;
    always #4 core_clk = ~core_clk;
    nmi_guard dut (.core_clk(core_clk), .srst(srst), .usr_nmi_set(uset), .sys_nmi_set(sset), .usr_vec_rd(urd),
        .sys_vec_rd(srd), .user_nmi_vector_register(uvec), .sys_nmi_vector(svec), .user_nonmaskable_irq(uirq),
        .system_nonmaskable_irq(sirq), .sys_handler_enter(enter), .sys_handler_return(ret),
        .instr_retire(retire), .irq_pending(irq), .irq_grant(grant), .acc_valid(accv), .acc_addr(addr),
        .boot_protect_en(pen), .boot_loader_region_in_ram(pram), .security_reset(sec));
    cpu_model cpu (.core_clk(core_clk), .go(go), .sys_handler_enter(enter), .sys_handler_return(ret),
        .instr_retire(retire));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic t_guard;
        logic [19:0] tbl [8] = '{20'h01C00, 20'h01C0F, 20'h01C10, 20'h01D00, 20'h01E00, 20'h01F00, 20'h02000, 20'h02B00};
        foreach (tbl[i]) begin
            addr <= tbl[i];
            accv <= 1'b1;
            cyc(1);
            accv <= 1'b0;
            chk(16'(sec), 16'(i < 2));
            cyc(1);
        end
        pram <= 1'b0;
        addr <= 20'h01C05;
        accv <= 1'b1;
        cyc(1);
        accv <= 1'b0;
        pram <= 1'b1;
        chk(16'(sec), 16'h0000);
        cyc(1);
        $display("guard test done");
    endtask
    // one-cycle user vector read, optionally with new flags arriving in the same cycle
    task automatic rd(input logic [3:0] s, input logic [15:0] exp);
        urd <= 1'b1;
        uset <= s;
        cyc(1);
        urd <= 1'b0;
        uset <= 4'h0;
        chk(uvec, exp);
        addr <= 20'h04000;
        accv <= 1'b1;
        cyc(1);
        accv <= 1'b0;
    endtask
    task automatic t_user;
        uset <= 4'h5;
        cyc(1);
        uset <= 4'h0;
        chk(uvec, 16'h0002);
        cyc(1);
        rd(4'h0, 16'h0006);
        rd(4'h1, 16'h0002);
        rd(4'h0, 16'h0000);
        $display("user test done");
    endtask
    task automatic t_sys;
        uset <= 4'h8;
        sset <= 4'h2;
        cyc(1);
        {uset, sset} <= 8'h00;
        chk(svec, 16'h0004);
        chk(uvec, 16'h0008);
        chk(16'(uirq), 16'h0000);
        chk(16'(sirq), 16'h0001);
        srd <= 1'b1;
        cyc(1);
        srd <= 1'b0;
        chk(16'(uirq), 16'h0001);
        chk(16'(sirq), 16'h0000);
        $display("system test done");
    endtask
    task automatic t_ret;
        irq <= 1'b1;
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        cyc(1);
        chk(16'(uirq), 16'h0000);
        chk(16'(grant), 16'h0000);
        cyc(2);
        chk(16'(grant), 16'h0000);
        cyc(2);
        chk(16'(grant), 16'h0001);
        irq <= 1'b0;
        rd(4'h0, 16'h0000);
        $display("return test done");
    endtask
    initial begin
        cyc(5);
        srst <= 1'b0;
        cyc(1);
        t_guard();
        t_user();
        t_sys();
        t_ret();
        summarize();
    end
    initial begin
        #20000;
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire
